// ### rtl/sequencer_params.svh
// Constants for the automatic stage speed sequencer: register indices, field
// positions, reset values, ranges and the one-second time base.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH

// Register indices on the plain register port.
`define REG_MODE 8'h00
`define REG_CYCLES 8'h01
`define REG_DUR_BASE 8'h02
`define REG_DUR_LAST 8'h11
`define REG_RESTORE 8'h12
`define REG_LOCK 8'h13
`define REG_FREQ_SRC 8'h14
`define REG_MOTOR_A 8'h15
`define REG_MOTOR_B 8'h16
`define REG_FAULT_BASE 8'h18
`define REG_FAULT_LAST 8'h1b
`define REG_STAT_CYCLE 8'h1c
`define REG_STAT_STAGE 8'h1d
`define REG_SPEED_BASE 8'h20
`define REG_SPEED_LAST 8'h2f

// Status field positions in the stage status register.
`define STAT_STAGE_LSB 0
`define STAT_STATE_LSB 4
`define STAT_VARIANT_LSB 8

// Widths and counts.
`define REG_W 16
`define ADDR_W 8
`define STAGE_NUM 16
`define FAULT_NUM 4
`define CYC_W 12

// Mode values of the sequence mode selector.
`define MODE_OFF 16'h0000
`define MODE_RECIP_STOP 16'h0001
`define MODE_CYCLIC_STOP 16'h0002
`define MODE_RECIP_HOME 16'h0003
`define MODE_CYCLIC_HOME 16'h0004

// Restore selector values.
`define RESTORE_NONE 16'h0000
`define RESTORE_LAST_VARIANT 16'h0004
`define RESTORE_CLEAR_FAULTS 16'h0005

// Reset values and ranges.
`define MODE_RESET 16'h0000
`define CYCLES_RESET 16'h0001
`define CYCLES_MIN 16'h0001
`define CYCLES_MAX 16'h0bb8
`define HOME_DUR_RESET 16'h0001
`define STAGE_DUR_RESET 16'h0000
`define SPEED_RESET 16'h0000
`define FREQ_SRC_RESET 16'h0000
`define MOTOR_RESET 16'h0000
`define DUR_POS_MAX 16'h7530
`define DUR_NEG_MIN 16'h8ad0
`define LOCK_ON 16'h0001

// Last slot of each cycle order and the reciprocating turn slot.
`define RECIP_LAST_SLOT 5'h1f
`define CYCLIC_LAST_SLOT 5'h0f
`define RECIP_TURN_SLOT 5'h10

// Time base: period in seconds and the core clock rate in hertz.
`define TICK_PERIOD_S 1
`define CORE_CLK_HZ 50000000

`endif

// ### rtl/sequencer_pkg.sv
// Types shared by the stage sequencer and its time base.
// Assumes the constants header is on the include path.
`include "sequencer_params.svh"

package sequencer_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;

  // Whole state of the sequencer and its register file.
  typedef struct packed {
    logic [`REG_W-1:0] mode;
    logic [`REG_W-1:0] cycles;
    logic [`STAGE_NUM-1:0][`REG_W-1:0] dur;
    logic [`STAGE_NUM-1:0][`REG_W-1:0] speed;
    logic lock;
    logic [2:0] variant;
    logic [`REG_W-1:0] freq_src;
    logic [`REG_W-1:0] motor_a;
    logic [`REG_W-1:0] motor_b;
    logic [`FAULT_NUM-1:0][`REG_W-1:0] faults;
    seq_state_t fsm;
    logic [4:0] slot;
    logic [14:0] dwell;
    logic [`CYC_W-1:0] cycle_num;
    logic [`REG_W-1:0] rd_data;
    logic nvm_save;
    logic [`ADDR_W-1:0] nvm_addr;
  } seq_regs_t;

  // State of the one-second time base.
  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } tick_state_t;

endpackage

// ### rtl/second_tick.sv
// One-second tick generator for the stage sequencer.
// Assumes a free-running core clock; the tick is a one-cycle pulse.
`timescale 1ns/1ps
`include "sequencer_params.svh"

module second_tick #(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_S * `CORE_CLK_HZ
) (
  input wire logic core_clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  output logic tick_o // One-cycle pulse once per period.
);

  sequencer_pkg::tick_state_t st; // Registered state.
  sequencer_pkg::tick_state_t next_st; // Next state.

  // Count to the end of the period, then wrap and pulse.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count >= 32'(TICK_CYCLES - 1)) begin
      next_st.count = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule // second_tick

// ### rtl/stage_sequencer.sv
// Automatic multi-speed stage sequencer with its parameter registers,
// fault history, factory restore and write lock.
// Assumes inputs synchronous to core_clk_i and a one-cycle register port.
`timescale 1ns/1ps
`include "sequencer_params.svh"

// Function
// - Mode zero: no sequence, normal speed
// - Reciprocating: home up to 15, back down
// - Cyclic: home through 15, then wrap
// - Modes 1 and 2 stop after cycles
// - Modes 3 and 4 hold home speed after
// - Count cycles against count 1 to 3000
// - Display cycle number and stage while running
// - Auto modes override; obey run, pause terminals
// - Sixteen signed durations, range plus minus 30000
// - Negative duration reverse, magnitude is dwell
// - Zero duration stage is skipped at once
// - Zero hertz stage holds still, still timed
// - Restore keeps motor settings and fault history
// - Each fault is logged into history slots
// - Restore value 5 clears fault history
// - Unlocked: in-range writes accepted and saved
// - Locked: most writes rejected, reads remain
// - Locked: source and first speed still writable
module stage_sequencer #(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_S * `CORE_CLK_HZ
) (
  input wire logic core_clk_i, // Core clock, 50 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [`ADDR_W-1:0] addr_i, // Register index.
  input wire logic [`REG_W-1:0] wr_data_i, // Write data.
  input wire logic wr_stb_i, // Write strobe, one cycle.
  input wire logic rd_stb_i, // Read strobe, one cycle.
  output logic [`REG_W-1:0] rd_data_o, // Read data, cycle after strobe.
  input wire logic auto_run_i, // Auto-run terminal, high runs.
  input wire logic pause_i, // Pause terminal, high freezes timing.
  input wire logic fault_i, // Fault event pulse.
  input wire logic [`REG_W-1:0] fault_code_i, // Code of that fault.
  input wire logic normal_run_i, // Run from normal command sources.
  input wire logic normal_reverse_i, // Direction from normal sources.
  input wire logic [`REG_W-1:0] normal_speed_i, // Speed from normal sources.
  output logic seq_active_o, // Sequencer owns the speed command.
  output logic run_o, // Motor run command.
  output logic reverse_o, // Motor reverse command.
  output logic [3:0] speed_select_o, // Active speed slot, 0 is home.
  output logic [`REG_W-1:0] speed_hz_o, // Speed command value.
  output logic [`CYC_W-1:0] disp_cycle_o, // Cycle number for the display.
  output logic [3:0] disp_stage_o, // Stage number for the display.
  output logic nvm_save_o, // Pulse: store a changed value.
  output logic [`ADDR_W-1:0] nvm_addr_o // Index of that value.
);

  sequencer_pkg::seq_regs_t st; // Registered state.
  sequencer_pkg::seq_regs_t next_st; // Next state.
  logic tick; // One-second pulse.
  logic mode_auto; // A sequence mode is selected.
  logic mode_recip; // Reciprocating order selected.
  logic mode_hold; // Keep home speed after the last cycle.
  logic [3:0] cur_stage; // Stage of the current slot.
  logic [`REG_W-1:0] cur_dur; // Duration of the current stage.

  // Time base for the dwell counters.
  second_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_second_tick (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .tick_o(tick)
  );

  // Map a slot to its stage; the second half of a reciprocating cycle runs down.
  function automatic logic [3:0] stage_of(input logic [4:0] slot, input logic recip);
    logic [4:0] down;
    down = `RECIP_LAST_SLOT - slot;
    if (recip && slot[4]) begin
      stage_of = down[3:0];
    end else begin
      stage_of = slot[3:0];
    end
  endfunction

  // Magnitude of a signed duration, the dwell in seconds.
  function automatic logic [14:0] dwell_of(input logic [`REG_W-1:0] d);
    logic [`REG_W-1:0] neg;
    neg = `REG_W'(0) - d;
    dwell_of = d[`REG_W-1] ? neg[14:0] : d[14:0];
  endfunction

  // Mode decode.
  always_comb begin
    mode_auto = (st.mode >= `MODE_RECIP_STOP) && (st.mode <= `MODE_CYCLIC_HOME);
    mode_recip = (st.mode == `MODE_RECIP_STOP) || (st.mode == `MODE_RECIP_HOME);
    mode_hold = (st.mode == `MODE_RECIP_HOME) || (st.mode == `MODE_CYCLIC_HOME);
    cur_stage = (st.fsm == sequencer_pkg::SEQ_RUN) ? stage_of(st.slot, mode_recip) : 4'h0;
    cur_dur = st.dur[cur_stage];
  end

  // All next-state logic: register port, restore, faults and the sequencer.
  always_comb begin
    logic wr_ok;
    logic last_slot;
    logic advance;
    logic [4:0] nslot;
    wr_ok = 1'b0;
    last_slot = 1'b0;
    advance = 1'b0;
    nslot = 5'h0;
    next_st = st;
    next_st.nvm_save = 1'b0;
    next_st.rd_data = '0;

    // Locked writes reach only the source, first speed and the lock itself.
    if (wr_stb_i) begin
      wr_ok = !st.lock || (addr_i == `REG_FREQ_SRC) || (addr_i == `REG_SPEED_BASE)
        || (addr_i == `REG_LOCK);
    end

    // Register writes; out-of-range values are refused and not stored.
    if (wr_ok) begin
      if (addr_i == `REG_MODE) begin
        if (wr_data_i <= `MODE_CYCLIC_HOME) begin
          next_st.mode = wr_data_i;
          next_st.nvm_save = 1'b1;
        end
      end else if (addr_i == `REG_CYCLES) begin
        if ((wr_data_i >= `CYCLES_MIN) && (wr_data_i <= `CYCLES_MAX)) begin
          next_st.cycles = wr_data_i;
          next_st.nvm_save = 1'b1;
        end
      end else if ((addr_i >= `REG_DUR_BASE) && (addr_i <= `REG_DUR_LAST)) begin
        if (wr_data_i[`REG_W-1] ? (wr_data_i >= `DUR_NEG_MIN) : (wr_data_i <= `DUR_POS_MAX)) begin
          next_st.dur[4'(addr_i - `REG_DUR_BASE)] = wr_data_i;
          next_st.nvm_save = 1'b1;
        end
      end else if (addr_i == `REG_RESTORE) begin
        if ((wr_data_i >= `CYCLES_MIN) && (wr_data_i <= `RESTORE_LAST_VARIANT)) begin
          // Factory reload; motor settings and fault history are left alone.
          next_st.mode = `MODE_RESET;
          next_st.cycles = `CYCLES_RESET;
          for (int i = 0; i < `STAGE_NUM; i++) begin
            next_st.dur[i] = (i == 0) ? `HOME_DUR_RESET : `STAGE_DUR_RESET;
            next_st.speed[i] = `SPEED_RESET;
          end
          next_st.freq_src = `FREQ_SRC_RESET;
          next_st.lock = 1'b0;
          next_st.variant = wr_data_i[2:0];
          next_st.nvm_save = 1'b1;
        end else if (wr_data_i == `RESTORE_CLEAR_FAULTS) begin
          next_st.faults = '0;
          next_st.nvm_save = 1'b1;
        end
      end else if (addr_i == `REG_LOCK) begin
        next_st.lock = (wr_data_i == `LOCK_ON);
        next_st.nvm_save = 1'b1;
      end else if (addr_i == `REG_FREQ_SRC) begin
        next_st.freq_src = wr_data_i;
        next_st.nvm_save = 1'b1;
      end else if (addr_i == `REG_MOTOR_A) begin
        next_st.motor_a = wr_data_i;
        next_st.nvm_save = 1'b1;
      end else if (addr_i == `REG_MOTOR_B) begin
        next_st.motor_b = wr_data_i;
        next_st.nvm_save = 1'b1;
      end else if ((addr_i >= `REG_SPEED_BASE) && (addr_i <= `REG_SPEED_LAST)) begin
        next_st.speed[4'(addr_i - `REG_SPEED_BASE)] = wr_data_i;
        next_st.nvm_save = 1'b1;
      end
    end
    if (next_st.nvm_save) begin
      next_st.nvm_addr = addr_i;
    end

    // A fault shifts the history; it lands after a clear in the same cycle.
    if (fault_i) begin
      for (int i = `FAULT_NUM - 1; i > 0; i--) begin
        next_st.faults[i] = next_st.faults[i-1];
      end
      next_st.faults[0] = fault_code_i;
      next_st.nvm_save = 1'b1;
      next_st.nvm_addr = `REG_FAULT_BASE;
    end

    // Register reads; unmapped indices read as zero.
    if (rd_stb_i) begin
      if (addr_i == `REG_MODE) begin
        next_st.rd_data = st.mode;
      end else if (addr_i == `REG_CYCLES) begin
        next_st.rd_data = st.cycles;
      end else if ((addr_i >= `REG_DUR_BASE) && (addr_i <= `REG_DUR_LAST)) begin
        next_st.rd_data = st.dur[4'(addr_i - `REG_DUR_BASE)];
      end else if (addr_i == `REG_RESTORE) begin
        next_st.rd_data = {13'h0, st.variant};
      end else if (addr_i == `REG_LOCK) begin
        next_st.rd_data = {15'h0, st.lock};
      end else if (addr_i == `REG_FREQ_SRC) begin
        next_st.rd_data = st.freq_src;
      end else if (addr_i == `REG_MOTOR_A) begin
        next_st.rd_data = st.motor_a;
      end else if (addr_i == `REG_MOTOR_B) begin
        next_st.rd_data = st.motor_b;
      end else if ((addr_i >= `REG_FAULT_BASE) && (addr_i <= `REG_FAULT_LAST)) begin
        next_st.rd_data = st.faults[2'(addr_i - `REG_FAULT_BASE)];
      end else if (addr_i == `REG_STAT_CYCLE) begin
        next_st.rd_data = {4'h0, st.cycle_num};
      end else if (addr_i == `REG_STAT_STAGE) begin
        // Fields sit at their named positions; the bits between them read as zero.
        next_st.rd_data[`STAT_STAGE_LSB +: 4] = cur_stage;
        next_st.rd_data[`STAT_STATE_LSB +: 2] = 2'(st.fsm);
        next_st.rd_data[`STAT_VARIANT_LSB +: 3] = st.variant;
      end else if ((addr_i >= `REG_SPEED_BASE) && (addr_i <= `REG_SPEED_LAST)) begin
        next_st.rd_data = st.speed[4'(addr_i - `REG_SPEED_BASE)];
      end
    end

    // Sequencer; any loss of mode or of the run terminal returns it to idle.
    last_slot = mode_recip ? (st.slot == `RECIP_LAST_SLOT) : (st.slot == `CYCLIC_LAST_SLOT);
    if (!mode_auto || !auto_run_i) begin
      next_st.fsm = sequencer_pkg::SEQ_IDLE;
      next_st.slot = 5'h0;
      next_st.dwell = 15'h0;
      next_st.cycle_num = `CYC_W'(1);
    end else begin
      case (st.fsm)
        sequencer_pkg::SEQ_IDLE: begin
          next_st.fsm = sequencer_pkg::SEQ_RUN;
          next_st.slot = 5'h0;
          next_st.cycle_num = `CYC_W'(1);
          next_st.dwell = dwell_of(st.dur[0]);
        end
        sequencer_pkg::SEQ_RUN: begin
          // Pause freezes timing and skipping alike.
          if (!pause_i) begin
            if (cur_dur == '0) begin
              advance = 1'b1;
            end else if (tick) begin
              if (st.dwell <= 15'h1) begin
                advance = 1'b1;
              end else begin
                next_st.dwell = st.dwell - 15'h1;
              end
            end
          end
          if (advance) begin
            if (last_slot) begin
              if ({4'h0, st.cycle_num} >= st.cycles) begin
                next_st.fsm = sequencer_pkg::SEQ_DONE;
                next_st.slot = 5'h0;
              end else begin
                next_st.cycle_num = st.cycle_num + `CYC_W'(1);
                next_st.slot = 5'h0;
                next_st.dwell = dwell_of(st.dur[0]);
              end
            end else begin
              nslot = st.slot + 5'h1;
              next_st.slot = nslot;
              next_st.dwell = dwell_of(st.dur[stage_of(nslot, mode_recip)]);
            end
          end
        end
        sequencer_pkg::SEQ_DONE: begin
          next_st.fsm = sequencer_pkg::SEQ_DONE;
        end
        default: begin
          next_st.fsm = sequencer_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.cycles <= `CYCLES_RESET;
      st.dur[0] <= `HOME_DUR_RESET;
      st.cycle_num <= `CYC_W'(1);
    end else begin
      st <= next_st;
    end
  end

  // Speed command: the sequencer overrides normal sources in any auto mode.
  always_comb begin
    seq_active_o = mode_auto;
    if (mode_auto) begin
      run_o = (st.fsm == sequencer_pkg::SEQ_RUN) || ((st.fsm == sequencer_pkg::SEQ_DONE) && mode_hold);
      reverse_o = cur_dur[`REG_W-1];
      speed_hz_o = st.speed[cur_stage];
    end else begin
      run_o = normal_run_i;
      reverse_o = normal_reverse_i;
      speed_hz_o = normal_speed_i;
    end
  end

  assign speed_select_o = cur_stage;
  assign disp_cycle_o = st.cycle_num;
  assign disp_stage_o = cur_stage;
  assign rd_data_o = st.rd_data;
  assign nvm_save_o = st.nvm_save;
  assign nvm_addr_o = st.nvm_addr;

  // Helper for the wrap check: a slot advance is about to happen.
  logic advance_seen; // Sequencer will leave the current slot.
  assign advance_seen = mode_auto && auto_run_i && !pause_i && ((cur_dur == '0) || (tick && (st.dwell <= 15'h1)));

  // Checks of the sequencer and register behaviour.
  sequence s_run_tick;
    (st.fsm == sequencer_pkg::SEQ_RUN) && mode_auto && auto_run_i && !pause_i && tick
      && (cur_dur != '0) && (st.dwell > 15'h1);
  endsequence

  sequence s_locked_write;
    wr_stb_i && st.lock && (addr_i == `REG_MODE);
  endsequence

  a_mode_zero_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.mode == `MODE_OFF) |-> (!seq_active_o && (run_o == normal_run_i))) else $error("Mode zero not idle.");
  a_recip_turn: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_RUN) && mode_recip && (st.slot == `RECIP_TURN_SLOT)) |-> (speed_select_o == 4'hf))
    else $error("Reciprocating turn stage wrong.");
  a_cyclic_wrap: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_RUN) && !mode_recip && (st.slot == `CYCLIC_LAST_SLOT) && advance_seen)
    |=> (st.slot == 5'h0)) else $error("Cyclic order did not wrap.");
  a_stop_done: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_DONE) && mode_auto && !mode_hold) |-> !run_o) else $error("Motor not stopped.");
  a_hold_home: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_DONE) && mode_hold) |-> (run_o && (speed_select_o == 4'h0)))
    else $error("Home speed not held.");
  a_cycle_bound: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.fsm == sequencer_pkg::SEQ_RUN) |-> ((st.cycle_num != '0) && ({4'h0, st.cycle_num} <= st.cycles)))
    else $error("Cycle number out of range.");
  a_skip_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_RUN) && mode_auto && auto_run_i && !pause_i && (cur_dur == '0))
    |=> ((st.slot != $past(st.slot)) || (st.fsm != sequencer_pkg::SEQ_RUN))) else $error("Zero stage not skipped.");
  a_reverse_sign: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((st.fsm == sequencer_pkg::SEQ_RUN) && mode_auto && cur_dur[`REG_W-1]) |-> reverse_o)
    else $error("Negative duration not reverse.");
  a_lock_reject: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_locked_write |=> $stable(st.mode)) else $error("Locked write stored.");
  a_fault_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_stb_i && !st.lock && (addr_i == `REG_RESTORE) && (wr_data_i == `RESTORE_CLEAR_FAULTS) && !fault_i)
    |=> (st.faults == '0)) else $error("Fault history not cleared.");
  a_tick_decr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_run_tick |=> (st.dwell == $past(st.dwell) - 15'h1)) else $error("Dwell not decremented.");

endmodule // stage_sequencer

// ### verification/terminal_model.sv
// Operator-side model: the auto-run and pause terminals and the fault event line.
// Assumes callers share the core clock; every line changes just after a rising edge.
`timescale 1ns/1ps

module terminal_model (
  input wire logic core_clk_i, // Core clock.
  output logic auto_run_o, // Auto-run terminal level.
  output logic pause_o, // Pause terminal level.
  output logic fault_o, // Fault event pulse.
  output logic [15:0] fault_code_o // Code that goes with the pulse.
);
  // All lines start idle so the sequencer sees no request at reset.
  initial begin
    auto_run_o = 1'b0;
    pause_o = 1'b0;
    fault_o = 1'b0;
    fault_code_o = 16'h0000;
  end

  // Terminal levels move one edge after the request, like a debounced input.
  task automatic set_run(input logic v);
    @(posedge core_clk_i);
    auto_run_o <= v;
  endtask

  // Pause freezes the sequence timing while it is high.
  task automatic set_pause(input logic v);
    @(posedge core_clk_i);
    pause_o <= v;
  endtask

  // The code is inverted after the pulse so a late sample cannot match by luck.
  task automatic pulse_fault(input logic [15:0] c);
    @(posedge core_clk_i);
    fault_o <= 1'b1;
    fault_code_o <= c;
    @(posedge core_clk_i);
    fault_o <= 1'b0;
    fault_code_o <= ~c;
  endtask
endmodule // terminal_model

// ### verification/stage_sequencer_test.sv
// Self-checking bench for the stage sequencer: register port, lock, restore, faults, sequences.
// Assumes a short tick of ten clocks so every sequence finishes within a few hundred cycles.
`timescale 1ns/1ps
`include "sequencer_params.svh"

module stage_sequencer_test;
  logic core_clk_i, rstn_i, wr_stb, rd_stb, auto_run, pause, fault, seq_act, run, rev, nvm_save, rev3;
  logic [7:0] addr, nvm_addr;
  logic [15:0] wdata, rdata, fcode, hz, nspd;
  logic nrun, nrev; // Normal command sources, which only count while mode is zero.
  logic [3:0] sel, dstage;
  logic [11:0] dcyc, cyc_seen;
  logic [3:0] seen[$], want[$];
  int n_mismatch = 0, samples_checked = 0;
  logic [7:0] ra[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h11, 8'h13, 8'h17, 8'h18};
  logic [15:0] rv[8] = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

  stage_sequencer #(.TICK_CYCLES(10)) u_stage_sequencer (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .addr_i(addr), .wr_data_i(wdata), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .rd_data_o(rdata),
    .auto_run_i(auto_run), .pause_i(pause), .fault_i(fault), .fault_code_i(fcode),
    .normal_run_i(nrun), .normal_reverse_i(nrev), .normal_speed_i(nspd), .seq_active_o(seq_act),
    .run_o(run), .reverse_o(rev), .speed_select_o(sel), .speed_hz_o(hz), .disp_cycle_o(dcyc),
    .disp_stage_o(dstage), .nvm_save_o(nvm_save), .nvm_addr_o(nvm_addr));
  terminal_model u_terminal_model (.core_clk_i(core_clk_i), .auto_run_o(auto_run), .pause_o(pause),
    .fault_o(fault), .fault_code_o(fcode));

  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write: one strobe cycle, taken at the next edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk_i);
    wr_stb <= 1'b0;
  endtask

  // Register read: data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk_i);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Record every change of the active stage while the sequencer drives the motor.
  always @(posedge core_clk_i) begin
    if (seq_act && run && (seen.size() == 0 || seen[$] !== sel)) begin
      seen.push_back(sel);
      cyc_seen <= dcyc;
      chk({12'h0, dstage}, {12'h0, sel});
      if (sel == 4'h3) begin
        rev3 <= rev && (hz == 16'h0000);
      end
    end
  end

  // Runs one mode; skipped stages still show for a clock, so the visit list is exact.
  task automatic runm(input logic [15:0] m, input logic [15:0] c, input bit recip, input bit hold);
    u_terminal_model.set_run(1'b0);
    repeat (2) @(posedge core_clk_i);
    wr(`REG_MODE, m);
    wr(`REG_CYCLES, c);
    seen.delete();
    want.delete();
    for (int k = 0; k < c; k++) begin
      for (int i = (k > 0 && recip) ? 1 : 0; i < 16; i++) want.push_back(4'(i));
      if (recip) for (int i = 14; i >= 0; i--) want.push_back(4'(i));
    end
    if (hold && !recip) want.push_back(4'h0);
    u_terminal_model.set_run(1'b1);
    for (int i = 0; i < 3000 && seen.size() < want.size(); i++) @(posedge core_clk_i);
    repeat (40) @(posedge core_clk_i);
    chk(16'(seen.size()), 16'(want.size()));
    foreach (want[i]) if (i < seen.size()) chk({12'h0, seen[i]}, {12'h0, want[i]});
    chk({15'h0, run}, {15'h0, hold});
    chk({4'h0, cyc_seen}, c);
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // A hang in any wait ends the run as a failure.
  initial begin
    #400us;
    n_mismatch++;
    close_out();
  end

  initial begin
    rstn_i = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    nrun = 1'b1;
    nrev = 1'b0;
    nspd = 16'h0123;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk({14'h0, seq_act, run}, 16'h0001);
    chk(hz, 16'h0123);
    // Mode zero must pass every normal source straight through, whatever its level.
    @(posedge core_clk_i);
    nrun <= 1'b0;
    nrev <= 1'b1;
    nspd <= 16'h0456;
    #1 chk({14'h0, run, rev}, 16'h0001);
    chk(hz, 16'h0456);
    wr(`REG_CYCLES, 16'h0000);
    rd(`REG_CYCLES, `CYCLES_RESET);
    wr(`REG_CYCLES, `CYCLES_MAX);
    wr(`REG_CYCLES, 16'h0bb9);
    rd(`REG_CYCLES, `CYCLES_MAX);
    wr(8'h04, 16'h7531);
    rd(8'h04, 16'h0000);
    wr(8'h04, `DUR_NEG_MIN);
    rd(8'h04, `DUR_NEG_MIN);
    wr(`REG_CYCLES, 16'h0002);
    #1 chk({7'h0, nvm_save, nvm_addr}, 16'h0101);
    // Locked: only the lock, the command source and the first stage speed take writes.
    wr(`REG_LOCK, `LOCK_ON);
    wr(`REG_CYCLES, 16'h0009);
    wr(`REG_MODE, `MODE_RECIP_STOP);
    rd(`REG_CYCLES, 16'h0002);
    rd(`REG_MODE, `MODE_OFF);
    wr(`REG_FREQ_SRC, 16'h0003);
    wr(`REG_SPEED_BASE, 16'h0005);
    rd(`REG_FREQ_SRC, 16'h0003);
    rd(`REG_SPEED_BASE, 16'h0005);
    wr(`REG_LOCK, 16'h0000);
    u_terminal_model.pulse_fault(16'h0007);
    u_terminal_model.pulse_fault(16'h0009);
    rd(`REG_FAULT_BASE, 16'h0009);
    rd(8'h19, 16'h0007);
    wr(`REG_MOTOR_A, 16'h0042);
    for (int v = 1; v <= 4; v++) begin
      wr(`REG_CYCLES, 16'h0005);
      wr(`REG_RESTORE, 16'(v));
      rd(`REG_CYCLES, `CYCLES_RESET);
      rd(`REG_RESTORE, 16'(v));
      rd(`REG_FAULT_BASE, 16'h0009);
      rd(`REG_MOTOR_A, 16'h0042);
    end
    wr(`REG_CYCLES, 16'h0007);
    wr(`REG_RESTORE, `RESTORE_NONE);
    rd(`REG_CYCLES, 16'h0007);
    wr(`REG_RESTORE, `RESTORE_CLEAR_FAULTS);
    rd(`REG_FAULT_BASE, 16'h0000);
    rd(8'h19, 16'h0000);
    // Pause held from the start must keep the home slot for many ticks.
    // Stage 3 runs two ticks in reverse at zero hertz, so the dwell countdown is exercised.
    wr(8'h05, 16'hfffe);
    wr(`REG_SPEED_BASE, 16'h0321);
    wr(`REG_MODE, `MODE_CYCLIC_STOP);
    u_terminal_model.set_pause(1'b1);
    u_terminal_model.set_run(1'b1);
    repeat (50) @(posedge core_clk_i);
    #1 chk({9'h0, rev, seq_act, run, sel}, 16'h0030);
    chk(hz, 16'h0321);
    rd(`REG_STAT_CYCLE, 16'h0001);
    rd(`REG_STAT_STAGE, 16'h0410);
    u_terminal_model.set_pause(1'b0);
    runm(`MODE_CYCLIC_STOP, 16'h0002, 1'b0, 1'b0);
    chk({15'h0, rev3}, 16'h0001);
    runm(`MODE_RECIP_STOP, 16'h0002, 1'b1, 1'b0);
    runm(`MODE_RECIP_HOME, 16'h0001, 1'b1, 1'b1);
    runm(`MODE_CYCLIC_HOME, 16'h0001, 1'b0, 1'b1);
    close_out();
  end
endmodule // stage_sequencer_test
